// ### rtl/clv_servo_pkg.sv
// Purpose: Shared constants and types for the spindle servo controller.
// Assumes: 250 MHz system clock; all strobe and frame inputs synchronous to it.
// Notes:   Register map is word aligned on a 32-bit Avalon-MM slave.
//
// Summary of operation
// - Servo action mode follows the value software writes into the mode register.
// - Forward: drive high, phase output released, filter low, motor on.
// - Reverse: drive low, phase output released, filter low, motor on.
// - Speed: correct frame sync is 22 VCO periods; longer noisy pulses rejected.
// - Speed: width measured with peak and bottom hold, result is synchronized frame.
// - Speed: peak hold is crystal frame /2 or /4, bottom hold /16 or /32.
// - Speed: width under 22T drives low, 22T releases, 23T or more drives high.
// - Speed/seek: gain bit low cuts drive by about 12 dB; gain bit high gives full drive.
// - Speed: phase output released, filter low, motor on.
// - Seek: peak hold from 8.4672 MHz/256 tick, bottom hold crystal frame /16 or /32.
// - Seek: phase output released, filter low, motor on.
// - Phase: drive shows phase error of playback/crystal or read/write base frames /4.
// - Phase: phase output high (high width minus 278T) times 32 after frame fall.
// - Auto: sample lock each frame; high picks phase, eight lows pick speed.
// - Gain/hold register picks peak period, bottom period and gain.
// - VCO rough mode uses the VCO frame in place of the crystal frame.
// - Stop: drive low, phase output released, filter low, motor off.
// - Lock flag high only when playback sync coincides with generated sync.
package clv_servo_pkg;

  localparam logic [3:0] OFS_MODE   = 4'h0;
  localparam logic [3:0] OFS_GAIN   = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;

  // Mode register fields
  localparam int MODE_LSB    = 0;
  localparam int REF_SEL_BIT = 3;
  // Gain/hold register fields
  localparam int PEAK_DIV4_BIT    = 0;
  localparam int BOTTOM_DIV32_BIT = 1;
  localparam int GAIN_HIGH_BIT    = 2;
  // Status register fields
  localparam int ST_ACT_LSB   = 0;
  localparam int ST_LOCK_BIT  = 3;
  localparam int ST_AUTOP_BIT = 4;
  localparam int ST_WIDTH_LSB = 8;

  localparam logic [2:0] MODE_STOP    = 3'h0;
  localparam logic [2:0] MODE_FWD     = 3'h1;
  localparam logic [2:0] MODE_REV     = 3'h2;
  localparam logic [2:0] MODE_SPEED   = 3'h3;
  localparam logic [2:0] MODE_SEEK    = 3'h4;
  localparam logic [2:0] MODE_PHASE   = 3'h5;
  localparam logic [2:0] MODE_AUTO    = 3'h6;
  localparam logic [2:0] MODE_VCO     = 3'h7;

  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [2:0] GAIN_RESET = 3'h4;

  localparam logic [7:0]  SYNC_WIDTH_T  = 8'h16;  // 22 VCO periods
  localparam logic [9:0]  PHASE_OFS_T   = 10'h116; // 278 periods of VCO/2
  localparam int          PHASE_SCALE_SH = 5;      // times 32
  localparam logic [3:0]  UNLOCK_FRAMES = 4'h8;
  localparam logic [4:0]  DIV16_MASK    = 5'h0F;
  localparam logic [4:0]  DIV32_MASK    = 5'h1F;
  localparam logic [1:0]  GAIN_DUTY_MAX = 2'h3;   // 1 in 4 duty is about -12 dB

  typedef enum logic [2:0] {
    ACT_STOP, ACT_FWD, ACT_REV, ACT_SPEED, ACT_SEEK, ACT_PHASE
  } servo_act_t;

  typedef struct packed {
    logic drive_out;
    logic drive_oe;
    logic phase_out;
    logic phase_oe;
    logic filter_ctl;
    logic motor_on;
  } motor_pins_t;

endpackage

// ### rtl/sync_width_hold.sv
// Purpose: Peak/bottom hold measurement of the recovered frame sync width.
// Assumes: vco_tick marks one VCO period; hold ticks are one-cycle pulses.
// Notes:   A noisy long pulse only survives if it persists over every peak window.
`timescale 1ns/10ps
`default_nettype none
module sync_width_hold
  import clv_servo_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       vco_tick,
  input  wire logic       sync_in,
  input  wire logic       peak_tick,
  input  wire logic       bottom_tick,
  output logic      [7:0] width
);

  typedef struct packed {
    logic       sync_prev;
    logic [7:0] run;
    logic [7:0] peak;
    logic [7:0] bottom;
    logic [7:0] width;
  } hold_state_t;

  hold_state_t s_q;
  hold_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.sync_prev = sync_in;
    if (sync_in && vco_tick && s_q.run != 8'hFF) begin
      s_d.run = s_q.run + 8'h01;
    end
    if (!sync_in && s_q.sync_prev) begin
      s_d.run = 8'h00;
      if (s_q.run > s_q.peak) begin
        s_d.peak = s_q.run;
      end
    end
    // Minimum of the peaks drops spurious over-long pulses
    if (peak_tick) begin
      s_d.peak = 8'h00;
      if (s_q.peak < s_q.bottom) begin
        s_d.bottom = s_q.peak;
      end
    end
    if (bottom_tick) begin
      s_d.width  = s_q.bottom;
      s_d.bottom = 8'hFF;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{sync_prev: 1'b0, run: 8'h00, peak: 8'h00, bottom: 8'hFF, width: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  assign width = s_q.width;

endmodule
`default_nettype wire

// ### rtl/clv_spindle_servo.sv
// Purpose: Constant linear velocity spindle servo with Avalon-MM control registers.
// Assumes: Frame and sync inputs are levels synchronous to REF_CLK; ticks are pulses.
// Notes:   Three-state motor pins are split into value and enable; the pad resolves them.
//
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module clv_spindle_servo
  import clv_servo_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        VCO_TICK,
  input  wire logic        SEEK_TICK,
  input  wire logic        CRYSTAL_FRAME_CLOCK,
  input  wire logic        VCO_FRAME_CLOCK,
  input  wire logic        PLAYBACK_FRAME_CLOCK,
  input  wire logic        READ_BASE_FRAME,
  input  wire logic        WRITE_BASE_FRAME,
  input  wire logic        FRAME_SYNC_IN,
  input  wire logic        PLAYBACK_SYNC_PULSE,
  input  wire logic        GENERATED_SYNC_PULSE,
  output logic             SPINDLE_DRIVE_OUT,
  output logic             SPINDLE_DRIVE_OE,
  output logic             SPINDLE_PHASE_OUT,
  output logic             SPINDLE_PHASE_OE,
  output logic             SPINDLE_FILTER_CTL,
  output logic             SPINDLE_MOTOR_ON,
  output logic             FRAME_SYNC_LOCKED
);

  typedef struct packed {
    logic [3:0]  mode_reg;
    logic [2:0]  gain_reg;
    logic        waitreq;
    logic [31:0] rdata;
    logic        ref_prev;
    logic        pb_prev;
    logic        rb_prev;
    logic        wb_prev;
    logic [4:0]  ref_cnt;
    logic [1:0]  div_a;
    logic [1:0]  div_b;
    logic        half_tick;
    logic [9:0]  high_width;
    logic [14:0] phase_cnt;
    logic        phase_level;
    logic        locked;
    logic        auto_phase;
    logic [3:0]  low_count;
    logic [1:0]  duty_cnt;
    servo_act_t  act;
    motor_pins_t pins;
  } servo_state_t;

  servo_state_t s_q;
  servo_state_t s_d;

  logic [7:0] sync_width;
  logic       ref_frame;
  logic       ref_rise;
  logic       pb_rise;
  logic       pb_fall;
  logic       peak_tick;
  logic       bottom_tick;
  logic       seek_active;
  logic       cmp_a_rise;
  logic       cmp_b_rise;
  logic [2:0] mode_sel;
  logic       ref_sel;

  assign mode_sel = s_q.mode_reg[MODE_LSB +: 3];
  assign ref_sel  = s_q.mode_reg[REF_SEL_BIT];

  // VCO rough mode swaps the crystal frame for the VCO-derived frame
  assign ref_frame = (mode_sel == MODE_VCO) ? VCO_FRAME_CLOCK : CRYSTAL_FRAME_CLOCK;
  assign ref_rise  = ref_frame && !s_q.ref_prev;
  assign pb_rise   = PLAYBACK_FRAME_CLOCK && !s_q.pb_prev;
  assign pb_fall   = !PLAYBACK_FRAME_CLOCK && s_q.pb_prev;
  assign seek_active = (s_q.act == ACT_SEEK);

  // Hold clocks picked from the gain/hold register, except the seek peak clock, which is SEEK_TICK
  always_comb begin
    if (seek_active) begin
      peak_tick = SEEK_TICK;
    end else if (s_q.gain_reg[PEAK_DIV4_BIT]) begin
      peak_tick = ref_rise && (s_q.ref_cnt[1:0] == 2'h3);
    end else begin
      peak_tick = ref_rise && s_q.ref_cnt[0];
    end
    if (s_q.gain_reg[BOTTOM_DIV32_BIT]) begin
      bottom_tick = ref_rise && (s_q.ref_cnt == DIV32_MASK);
    end else begin
      bottom_tick = ref_rise && (s_q.ref_cnt[3:0] == DIV16_MASK[3:0]);
    end
  end

  sync_width_hold u_width (
    .clk         (REF_CLK),
    .rst         (SYS_RST),
    .vco_tick    (VCO_TICK),
    .sync_in     (FRAME_SYNC_IN),
    .peak_tick   (peak_tick),
    .bottom_tick (bottom_tick),
    .width       (sync_width)
  );

  // Phase comparison sources
  assign cmp_a_rise = ref_sel ? (READ_BASE_FRAME && !s_q.rb_prev) : pb_rise;
  assign cmp_b_rise = ref_sel ? (WRITE_BASE_FRAME && !s_q.wb_prev) : ref_rise;

  always_comb begin
    s_d = s_q;
    s_d.ref_prev = ref_frame;
    s_d.pb_prev  = PLAYBACK_FRAME_CLOCK;
    s_d.rb_prev  = READ_BASE_FRAME;
    s_d.wb_prev  = WRITE_BASE_FRAME;
    if (ref_rise) begin
      s_d.ref_cnt = s_q.ref_cnt + 5'h01;
    end

    // Bus slave: one wait cycle, then the answer edge where writes land
    // Waitrequest is kept as its own flop so the port needs no inverter
    if ((AVS_READ || AVS_WRITE) && s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      s_d.rdata  = 32'h0000_0000;
      if (AVS_READ) begin
        if (AVS_ADDRESS == OFS_MODE) begin
          s_d.rdata[3:0] = s_q.mode_reg;
        end else if (AVS_ADDRESS == OFS_GAIN) begin
          s_d.rdata[2:0] = s_q.gain_reg;
        end else if (AVS_ADDRESS == OFS_STATUS) begin
          s_d.rdata[ST_ACT_LSB +: 3]   = s_q.act;
          s_d.rdata[ST_LOCK_BIT]       = s_q.locked;
          s_d.rdata[ST_AUTOP_BIT]      = s_q.auto_phase;
          s_d.rdata[ST_WIDTH_LSB +: 8] = sync_width;
        end
      end
    end else begin
      s_d.waitreq = 1'b1;
    end
    if (AVS_WRITE && !s_q.waitreq && AVS_BYTEENABLE[0]) begin
      if (AVS_ADDRESS == OFS_MODE) begin
        s_d.mode_reg = AVS_WRITEDATA[3:0];
      end else if (AVS_ADDRESS == OFS_GAIN) begin
        s_d.gain_reg = AVS_WRITEDATA[2:0];
      end
    end

    // Lock only when both syncs land in the same cycle
    if (GENERATED_SYNC_PULSE) begin
      s_d.locked = PLAYBACK_SYNC_PULSE;
    end else if (PLAYBACK_SYNC_PULSE) begin
      s_d.locked = 1'b0;
    end

    // Automatic phase/speed selection once per playback frame
    if (mode_sel != MODE_AUTO && mode_sel != MODE_VCO) begin
      s_d.auto_phase = 1'b0;
      s_d.low_count  = 4'h0;
    end else if (pb_fall) begin
      if (s_q.locked) begin
        s_d.auto_phase = 1'b1;
        s_d.low_count  = 4'h0;
      end else if (s_q.low_count + 4'h1 >= UNLOCK_FRAMES) begin
        s_d.auto_phase = 1'b0;
        s_d.low_count  = UNLOCK_FRAMES;
      end else begin
        s_d.low_count = s_q.low_count + 4'h1;
      end
    end

    case (mode_sel)
      MODE_FWD:   s_d.act = ACT_FWD;
      MODE_REV:   s_d.act = ACT_REV;
      MODE_SPEED: s_d.act = ACT_SPEED;
      MODE_SEEK:  s_d.act = ACT_SEEK;
      MODE_PHASE: s_d.act = ACT_PHASE;
      MODE_AUTO,
      MODE_VCO:   s_d.act = s_d.auto_phase ? ACT_PHASE : ACT_SPEED;
      default:    s_d.act = ACT_STOP;
    endcase

    // Frame /4 dividers for the phase detector
    if (cmp_a_rise) begin
      s_d.div_a = s_q.div_a + 2'h1;
    end
    if (cmp_b_rise) begin
      s_d.div_b = s_q.div_b + 2'h1;
    end

    // High width of the playback frame in VCO/2 periods
    if (VCO_TICK) begin
      s_d.half_tick = !s_q.half_tick;
    end
    if (pb_rise) begin
      s_d.high_width = 10'h000;
    end else if (PLAYBACK_FRAME_CLOCK && VCO_TICK && s_q.half_tick
                 && s_q.high_width != 10'h3FF) begin
      s_d.high_width = s_q.high_width + 10'h001;
    end
    if (pb_fall) begin
      if (s_q.high_width > PHASE_OFS_T) begin
        s_d.phase_cnt   = {s_q.high_width - PHASE_OFS_T, 5'h00};
        s_d.phase_level = 1'b1;
      end else begin
        s_d.phase_cnt   = 15'h0000;
        s_d.phase_level = 1'b0;
      end
    end else if (VCO_TICK && s_q.half_tick && s_q.phase_level) begin
      s_d.phase_cnt = s_q.phase_cnt - 15'h0001;
      if (s_q.phase_cnt <= 15'h0001) begin
        s_d.phase_level = 1'b0;
      end
    end

    // Reduced-gain drive keeps one slot in four
    s_d.duty_cnt = (s_q.duty_cnt == GAIN_DUTY_MAX) ? 2'h0 : s_q.duty_cnt + 2'h1;

    s_d.pins.filter_ctl = 1'b0;
    s_d.pins.phase_out  = 1'b0;
    s_d.pins.phase_oe   = 1'b0;
    s_d.pins.drive_out  = 1'b0;
    s_d.pins.drive_oe   = 1'b1;
    s_d.pins.motor_on   = 1'b1;
    case (s_q.act)
      ACT_FWD: begin
        s_d.pins.drive_out = 1'b1;
      end
      ACT_REV: begin
        s_d.pins.drive_out = 1'b0;
      end
      ACT_SPEED,
      ACT_SEEK: begin
        // Width against the 22T nominal
        if (sync_width < SYNC_WIDTH_T) begin
          s_d.pins.drive_out = 1'b0;
        end else if (sync_width == SYNC_WIDTH_T) begin
          s_d.pins.drive_oe = 1'b0;
        end else begin
          s_d.pins.drive_out = 1'b1;
        end
        if (!s_q.gain_reg[GAIN_HIGH_BIT] && s_q.duty_cnt != 2'h0) begin
          s_d.pins.drive_oe = 1'b0;
        end
      end
      ACT_PHASE: begin
        // Leading comparison frame pulls the drive high, lagging pulls it low
        if (s_q.div_a[1] && !s_q.div_b[1]) begin
          s_d.pins.drive_out = 1'b1;
        end else if (!s_q.div_a[1] && s_q.div_b[1]) begin
          s_d.pins.drive_out = 1'b0;
        end else begin
          s_d.pins.drive_oe = 1'b0;
        end
        s_d.pins.phase_out = s_q.phase_level;
        s_d.pins.phase_oe  = 1'b1;
      end
      default: begin
        s_d.pins.motor_on = 1'b0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      s_q <= '0;
      s_q.mode_reg      <= MODE_RESET;
      s_q.gain_reg      <= GAIN_RESET;
      s_q.act           <= ACT_STOP;
      s_q.pins.drive_oe <= 1'b1;
      s_q.waitreq       <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign AVS_READDATA       = s_q.rdata;
  assign AVS_WAITREQUEST    = s_q.waitreq;
  assign SPINDLE_DRIVE_OUT  = s_q.pins.drive_out;
  assign SPINDLE_DRIVE_OE   = s_q.pins.drive_oe;
  assign SPINDLE_PHASE_OUT  = s_q.pins.phase_out;
  assign SPINDLE_PHASE_OE   = s_q.pins.phase_oe;
  assign SPINDLE_FILTER_CTL = s_q.pins.filter_ctl;
  assign SPINDLE_MOTOR_ON   = s_q.pins.motor_on;
  assign FRAME_SYNC_LOCKED  = s_q.locked;

endmodule
`default_nettype wire

// ### tb/clv_servo_assertions.sv
// Purpose: Port-level checks of the spindle servo.
// Assumes: One clock; synchronous active-high reset.
// Notes:   A mode write reaches the pins by the third sample after its write edge.
`timescale 1ns/10ps
`default_nettype none
module clv_servo_assertions
  import clv_servo_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  input wire logic [3:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        PLAYBACK_SYNC_PULSE,
  input wire logic        GENERATED_SYNC_PULSE,
  input wire logic        SPINDLE_DRIVE_OUT,
  input wire logic        SPINDLE_DRIVE_OE,
  input wire logic        SPINDLE_PHASE_OE,
  input wire logic        SPINDLE_FILTER_CTL,
  input wire logic        SPINDLE_MOTOR_ON,
  input wire logic        FRAME_SYNC_LOCKED
);
  logic wr_mode;
  assign wr_mode = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_MODE
                   && AVS_BYTEENABLE[0];
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  property p_mode(m, e);
    wr_mode && AVS_WRITEDATA[2:0] == m |-> ##3 e;
  endproperty
  a_reset_stop: assert property ($past(SYS_RST) |->
    !SPINDLE_MOTOR_ON && !SPINDLE_DRIVE_OUT && !SPINDLE_PHASE_OE)
    else $error("not in stop after reset");
  a_wait_answer: assert property ($rose(AVS_READ || AVS_WRITE) |=>
    !AVS_WAITREQUEST) else $error("bus answer late");
  a_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer longer than one cycle");
  a_filter_low: assert property (SPINDLE_FILTER_CTL == 1'b0)
    else $error("filter control high");
  a_fwd_pins: assert property (p_mode(MODE_FWD, SPINDLE_DRIVE_OUT &&
    SPINDLE_DRIVE_OE && SPINDLE_MOTOR_ON && !SPINDLE_PHASE_OE))
    else $error("forward pins wrong");
  a_rev_pins: assert property (p_mode(MODE_REV, !SPINDLE_DRIVE_OUT &&
    SPINDLE_DRIVE_OE && SPINDLE_MOTOR_ON && !SPINDLE_PHASE_OE))
    else $error("reverse pins wrong");
  a_stop_pins: assert property (p_mode(MODE_STOP, !SPINDLE_DRIVE_OUT &&
    !SPINDLE_MOTOR_ON && !SPINDLE_PHASE_OE)) else $error("stop pins wrong");
  a_speed_pins: assert property (p_mode(MODE_SPEED,
    SPINDLE_MOTOR_ON && !SPINDLE_PHASE_OE)) else $error("speed pins wrong");
  a_seek_pins: assert property (p_mode(MODE_SEEK,
    SPINDLE_MOTOR_ON && !SPINDLE_PHASE_OE)) else $error("seek pins wrong");
  a_lock_set: assert property (GENERATED_SYNC_PULSE && PLAYBACK_SYNC_PULSE
    |=> FRAME_SYNC_LOCKED) else $error("lock not set");
  a_lock_clear: assert property (GENERATED_SYNC_PULSE && !PLAYBACK_SYNC_PULSE
    |=> !FRAME_SYNC_LOCKED) else $error("lock not cleared");
  c_mode_write: cover property (wr_mode);
  c_locked: cover property (GENERATED_SYNC_PULSE && PLAYBACK_SYNC_PULSE);
  c_drive_hiz: cover property (!SPINDLE_DRIVE_OE && SPINDLE_MOTOR_ON);
endmodule
bind clv_spindle_servo clv_servo_assertions u_chk (
  .REF_CLK, .SYS_RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
  .AVS_BYTEENABLE, .AVS_WAITREQUEST, .PLAYBACK_SYNC_PULSE, .GENERATED_SYNC_PULSE,
  .SPINDLE_DRIVE_OUT, .SPINDLE_DRIVE_OE, .SPINDLE_PHASE_OE, .SPINDLE_FILTER_CTL,
  .SPINDLE_MOTOR_ON, .FRAME_SYNC_LOCKED
);
`default_nettype wire

// ### tb/spindle_driver_model.sv
// Purpose: Motor driver pads seen from the far side of the spindle pins.
// Assumes: Pads have no pull resistor.
// Notes:   A released pad shows the inverse of its last level, so hi-Z never reads as valid.
`timescale 1ns/10ps
`default_nettype none
module spindle_driver_model (
  input  wire logic clk,
  input  wire logic drv_o,
  input  wire logic drv_oe,
  input  wire logic ph_o,
  input  wire logic ph_oe,
  output logic      drv_pad,
  output logic      ph_pad
);
  logic drv_last = 1'b0;
  logic ph_last  = 1'b0;
  always @(posedge clk) begin
    if (drv_oe) drv_last <= drv_o;
    if (ph_oe) ph_last <= ph_o;
  end
  assign drv_pad = drv_oe ? drv_o : ~drv_last;
  assign ph_pad  = ph_oe ? ph_o : ~ph_last;
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Purpose: Self-checking bench for the spindle servo.
// Assumes: VCO tick every cycle, so sync widths count in clock cycles.
// Notes:   Frames last 80 cycles to keep bottom-hold periods short.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import clv_servo_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic        rd  = 1'b0;
  logic        wr  = 1'b0;
  logic [31:0] wd  = 32'h0;
  logic [3:0]  be  = 4'hF;
  logic        gs  = 1'b0;
  logic        ps  = 1'b0;
  logic        xf  = 1'b0;
  logic        pf  = 1'b0;
  logic        fs  = 1'b0;
  logic        sk  = 1'b0;
  logic        noise = 1'b0;
  logic [31:0] rdat, q, r;
  logic        wt, d_o, d_oe, p_o, p_oe, filt, mon, lock, d_pad;
  logic [4:0]  pins;
  int          fc = 0;
  int          nf = 0;
  int          sync_w = 22;
  int          cyc = 0;
  int          error_cnt = 0;
  int          n_tests = 0;
  assign pins = {d_pad & d_oe, d_oe, p_oe, filt, mon};
  always #2 clk = ~clk;
  // Noise adds a long pulse every fourth frame; bottom hold must ignore it
  always @(posedge clk) begin
    fc <= (fc == 79) ? 0 : fc + 1;
    if (fc == 79) nf <= nf + 1;
    xf <= fc < 40;
    pf <= fc < 40;
    sk <= fc == 0;
    fs <= fc >= 2 && fc < 2 + ((noise && nf % 4 == 0) ? 40 : sync_w);
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      error_cnt++;
      results();
    end
  end
  clv_spindle_servo u_clv_spindle_servo (
    .REF_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wt),
    .VCO_TICK(1'b1), .SEEK_TICK(sk), .CRYSTAL_FRAME_CLOCK(xf), .VCO_FRAME_CLOCK(xf),
    .PLAYBACK_FRAME_CLOCK(pf), .READ_BASE_FRAME(pf), .WRITE_BASE_FRAME(xf),
    .FRAME_SYNC_IN(fs), .PLAYBACK_SYNC_PULSE(ps), .GENERATED_SYNC_PULSE(gs),
    .SPINDLE_DRIVE_OUT(d_o), .SPINDLE_DRIVE_OE(d_oe), .SPINDLE_PHASE_OUT(p_o),
    .SPINDLE_PHASE_OE(p_oe), .SPINDLE_FILTER_CTL(filt), .SPINDLE_MOTOR_ON(mon),
    .FRAME_SYNC_LOCKED(lock)
  );
  spindle_driver_model u_spindle_driver_model (
    .clk(clk), .drv_o(d_o), .drv_oe(d_oe), .ph_o(p_o), .ph_oe(p_oe),
    .drv_pad(d_pad), .ph_pad()
  );
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wt !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 100) error_cnt++;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse(input logic p);
    @(posedge clk);
    gs <= 1'b1;
    ps <= p;
    @(posedge clk);
    gs <= 1'b0;
    ps <= 1'b0;
    @(posedge clk);
  endtask
  task automatic results;
    $display("errors=%0d tests=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Pins as {pad and enable, drive enable, phase enable, filter, motor on}
  function automatic logic [4:0] exp_pins(input logic [2:0] m, input int w);
    case (m)
      MODE_FWD: return 5'h19;
      MODE_REV: return 5'h09;
      MODE_SPEED, MODE_SEEK: return w < 22 ? 5'h09 : (w == 22 ? 5'h01 : 5'h19);
      default: return 5'h08;
    endcase
  endfunction
  initial begin
    logic [2:0] mlist[4];
    logic [2:0] alist[2];
    logic [4:0] mk;
    int         n;
    mlist = '{MODE_FWD, MODE_REV, MODE_SEEK, MODE_STOP};
    alist = '{MODE_AUTO, MODE_VCO};
    r = $urandom(32'h0695);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, OFS_MODE, 32'h0);
    chk(q, 32'h0);
    chk(32'(pins), 32'h08);
    bus(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    be <= 4'hE;
    bus(1'b1, OFS_GAIN, 32'h0);
    be <= 4'hF;
    bus(1'b0, OFS_GAIN, 32'h0);
    chk(q, {29'h0, GAIN_RESET});
    foreach (mlist[i]) begin
      r = $urandom;
      bus(1'b1, OFS_MODE, {r[31:3], mlist[i]});
      bus(1'b0, OFS_MODE, 32'h0);
      chk(q, {28'h0, r[3], mlist[i]});
      mk = (mlist[i] == MODE_SEEK) ? 5'h07 : 5'h1F;
      chk(32'(pins & mk), 32'(exp_pins(mlist[i], sync_w) & mk));
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(32'(q[2:0]), 32'(mlist[i]));
    end
    bus(1'b1, OFS_MODE, 32'(MODE_SPEED));
    for (int k = 0; k < 5; k++) begin
      r = $urandom;
      sync_w = (k == 3) ? 24 + r[3:0] : ((k == 4) ? 23 : 21 + k);
      noise <= (k == 1);
      bus(1'b1, OFS_GAIN, {29'h0, k != 4, r[1], (k != 1) & r[0]});
      repeat (8000) @(posedge clk);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(32'(q[15:8]), sync_w);
      if (k < 4) chk(32'(pins), 32'(exp_pins(MODE_SPEED, sync_w)));
      n = 0;
      repeat (100) begin
        @(posedge clk);
        n += d_oe;
      end
      chk(n, (k == 4) ? 25 : 100 * (sync_w != 22));
    end
    // Same-timed frames keep both /4 dividers equal; short high time keeps phase out low
    bus(1'b1, OFS_MODE, 32'(MODE_PHASE));
    repeat (400) @(posedge clk);
    chk(32'({pins, p_o}), 32'h0A);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(32'(q[2:0]), 32'(MODE_PHASE));
    foreach (alist[i]) begin
      bus(1'b1, OFS_MODE, 32'(alist[i]));
      pulse(1'b0);
      chk(32'(lock), 32'h0);
      repeat (800) @(posedge clk);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(32'(q[2:0]), 32'(MODE_SPEED));
      pulse(1'b1);
      chk(32'(lock), 32'h1);
      repeat (200) @(posedge clk);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(32'(q[4:0]), 32'h1D);
    end
    results();
  end
endmodule
`default_nettype wire
